// file: logic/i2c_master.sv
// I2C bus master with APB registers, error reporting and maskable interrupts.
// Operation
// - Written transmit byte is next data sent.
// - Enable cleared stops new bus activity.
// - Enable set allows commanded transactions.
// - Exactly one error code after each operation.
// - Fast select gives 400 kbps, else 100.
// - Bit divider derived from peripheral clock.
// - Clearing interrupt drops the interrupt output.
// - Clear mask clears only selected sources.
// - Only enabled sources drive interrupt line.
// - Timeout and data sources, individually maskable.
// - Master interrupt enable gates all sources.
// - Status readable raw and masked.
// - Line state: data bit 1, clock bit 0.
// - 12-bit clock-low timeout, upper 8 programmable.
// - 7-bit address plus read/write direction bit.
//
// Design decisions made here: the register offsets and the APB register port.
`timescale 1ns/1ps
module i2c_master
  import i2c_master_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  output logic irq
);

  typedef enum logic [6:0] {
    ST_IDLE = 7'b0000001,
    ST_START = 7'b0000010,
    ST_BIT = 7'b0000100,
    ST_ACK = 7'b0001000,
    ST_HOLD = 7'b0010000,
    ST_STOP = 7'b0100000,
    ST_RSTART = 7'b1000000
  } state_e;

  // ----------------------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------------------
  logic [2:0] ctrl_q;
  logic [7:0] addr_q;
  logic [7:0] tx_q;
  logic [7:0] rx_q;
  logic [1:0] irq_raw_q;
  logic [1:0] irq_en_q;
  logic [7:0] tmo_q;
  err_code_e err_q;
  line_s line_q;
  logic [31:0] prdata_q;
  logic irq_q;
  state_e state_q;

  wire logic acc = psel && penable;
  wire logic wr = acc && pwrite;
  wire logic wr_ctrl = wr && (paddr == OFF_CTRL);
  wire logic wr_addr = wr && (paddr == OFF_ADDR);
  wire logic wr_tx = wr && (paddr == OFF_TXDATA);
  wire logic wr_cmd = wr && (paddr == OFF_CMD);
  wire logic wr_en = wr && (paddr == OFF_IRQ_EN);
  wire logic wr_clr = wr && (paddr == OFF_IRQ_CLR);
  wire logic wr_tmo = wr && (paddr == OFF_TIMEOUT);
  wire logic busy = (state_q != ST_IDLE);
  wire logic [1:0] irq_masked = irq_raw_q & irq_en_q &
                                {2{ctrl_q[CTRL_IRQ_MASTER_EN_BIT]}};
  wire logic mapped = (paddr[1:0] == 2'h0) && (paddr <= OFF_TIMEOUT);

  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0;
    unique case (paddr)
      OFF_CTRL: rd_mux = {29'h0, ctrl_q};
      OFF_ADDR: rd_mux = {24'h0, addr_q};
      OFF_TXDATA: rd_mux = {24'h0, tx_q};
      OFF_RXDATA: rd_mux = {24'h0, rx_q};
      OFF_STATUS: rd_mux = {29'h0, err_q, busy};
      OFF_IRQ_RAW: rd_mux = {30'h0, irq_raw_q};
      OFF_IRQ_EN: rd_mux = {30'h0, irq_en_q};
      OFF_IRQ_MASKED: rd_mux = {30'h0, irq_masked};
      OFF_LINE: rd_mux = {30'h0, line_q.sda, line_q.scl};
      OFF_TIMEOUT: rd_mux = {24'h0, tmo_q};
      default: rd_mux = 32'h0;
    endcase
  end

  assign prdata = prdata_q;
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign irq = irq_q;

  // ----------------------------------------------------------------------------
  // Bit-rate divider
  // ----------------------------------------------------------------------------
  logic [7:0] div_q;
  wire logic [7:0] div_top = ctrl_q[CTRL_FAST_BIT] ? 8'(QTR_FAST - 1)
                                                    : 8'(QTR_STD - 1);
  wire logic tick = (div_q == 8'h0);

  // ----------------------------------------------------------------------------
  // Bus engine
  // ----------------------------------------------------------------------------
  logic [1:0] ph_q;
  logic [3:0] bit_q;
  logic [8:0] sh_q;
  logic addr_phase_q;
  logic dir_rd_q;
  logic stop_q;
  logic ack_q;
  logic scl_drv_q;
  logic sda_drv_q;
  logic done_q;
  logic [11:0] tmo_cnt_q;
  logic tmo_evt_q;
  logic tmo_hit_q;

  // Start commands only while enabled; a command in ST_HOLD continues a burst, in other busy states it is ignored.
  wire logic go = wr_cmd && ctrl_q[CTRL_ENABLE_BIT];
  wire logic last_ph = tick && (ph_q == 2'h3);
  wire logic out_bit = sh_q[8];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q <= 8'h0;
      ph_q <= 2'h0;
    end else begin
      div_q <= tick ? div_top : div_q - 8'h1;
      ph_q <= (state_q == ST_IDLE) ? 2'h0 : (tick ? ph_q + 2'h1 : ph_q);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ST_IDLE;
      bit_q <= 4'h0;
      sh_q <= 9'h0;
      addr_phase_q <= 1'b0;
      dir_rd_q <= 1'b0;
      stop_q <= 1'b0;
      ack_q <= 1'b0;
      scl_drv_q <= 1'b0;
      sda_drv_q <= 1'b0;
      err_q <= ERR_NONE;
      rx_q <= 8'h0;
      done_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      unique case (state_q)
        ST_IDLE: begin
          scl_drv_q <= 1'b0;
          sda_drv_q <= 1'b0;
          if (go && pwdata[CMD_START_BIT]) begin
            state_q <= ST_START;
            err_q <= ERR_NONE;
            dir_rd_q <= addr_q[0];
            stop_q <= pwdata[CMD_STOP_BIT];
            ack_q <= pwdata[CMD_ACK_BIT];
            sh_q <= {addr_q, 1'b0};
            addr_phase_q <= 1'b1;
          end
        end
        ST_START: if (last_ph) begin
          sda_drv_q <= 1'b1;
          state_q <= ST_BIT;
          bit_q <= 4'h0;
        end
        ST_BIT: begin
          if (tick && ph_q == 2'h0) begin
            scl_drv_q <= 1'b1;
          end
          if (tick && ph_q == 2'h1) begin
            sda_drv_q <= (bit_q == 4'h8) ? (addr_phase_q || !dir_rd_q ? 1'b0 : ack_q)
                         : (addr_phase_q || !dir_rd_q ? !out_bit : 1'b0);
          end
          if (tick && ph_q == 2'h2) begin
            scl_drv_q <= 1'b0;
          end
          if (last_ph) begin
            if (bit_q < 4'h8 && !addr_phase_q && dir_rd_q) begin
              rx_q <= {rx_q[6:0], sda_i};
            end
            // Lost arbitration: released SDA but the bus reads low.
            if (bit_q < 4'h8 && (addr_phase_q || !dir_rd_q) && out_bit && !sda_i) begin
              err_q <= err_code_arbitration_lost;
              sda_drv_q <= 1'b0;
              scl_drv_q <= 1'b0;
              state_q <= ST_IDLE;
              done_q <= 1'b1;
            end else if (bit_q == 4'h8) begin
              state_q <= ST_ACK;
            end
            sh_q <= {sh_q[7:0], 1'b0};
            bit_q <= bit_q + 4'h1;
          end
        end
        ST_ACK: begin
          if ((addr_phase_q || !dir_rd_q) && sda_i) begin
            err_q <= addr_phase_q ? ERR_ADDR_NACK : ERR_DATA_NACK;
            state_q <= ST_STOP;
          end else if (addr_phase_q && !dir_rd_q) begin
            addr_phase_q <= 1'b0;
            sh_q <= {tx_q, 1'b0};
            bit_q <= 4'h0;
            state_q <= ST_BIT;
          end else if (addr_phase_q) begin
            addr_phase_q <= 1'b0;
            bit_q <= 4'h0;
            state_q <= ST_BIT;
          end else begin
            state_q <= stop_q ? ST_STOP : ST_HOLD;
            done_q <= !stop_q;
          end
        end
        ST_HOLD: if (go) begin
          stop_q <= pwdata[CMD_STOP_BIT];
          ack_q <= pwdata[CMD_ACK_BIT];
          sh_q <= {tx_q, 1'b0};
          bit_q <= 4'h0;
          if (pwdata[CMD_START_BIT]) begin
            state_q <= ST_RSTART;
          end else if (!pwdata[CMD_STOP_BIT] || pwdata[CMD_ACK_BIT]) begin
            state_q <= ST_BIT;
          end else begin
            state_q <= ST_STOP;
          end
        end else if (wr_ctrl && !pwdata[CTRL_ENABLE_BIT]) begin
          state_q <= ST_STOP;
        end
        ST_RSTART: begin
          if (tick && ph_q == 2'h0) begin
            scl_drv_q <= 1'b1;
          end
          if (tick && ph_q == 2'h1) begin
            sda_drv_q <= 1'b0;
          end
          if (tick && ph_q == 2'h2) begin
            scl_drv_q <= 1'b0;
          end
          if (last_ph) begin
            sda_drv_q <= 1'b1;
            dir_rd_q <= addr_q[0];
            sh_q <= {addr_q, 1'b0};
            addr_phase_q <= 1'b1;
            state_q <= ST_BIT;
          end
        end
        ST_STOP: begin
          if (tick && ph_q == 2'h0) begin
            scl_drv_q <= 1'b1;
          end
          if (tick && ph_q == 2'h1) begin
            sda_drv_q <= 1'b1;
          end
          if (tick && ph_q == 2'h2) begin
            scl_drv_q <= 1'b0;
          end
          if (last_ph) begin
            sda_drv_q <= 1'b0;
            state_q <= ST_IDLE;
            done_q <= 1'b1;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------------------
  // Clock-low timeout and line state
  // ----------------------------------------------------------------------------
  wire logic tmo_hit = (tmo_q != 8'h0) && (tmo_cnt_q[11:4] == tmo_q);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tmo_cnt_q <= 12'h0;
      tmo_evt_q <= 1'b0;
      tmo_hit_q <= 1'b0;
      line_q <= '0;
    end else begin
      line_q <= '{scl: scl_i, sda: sda_i};
      tmo_hit_q <= tmo_hit;
      tmo_evt_q <= tmo_hit && !tmo_hit_q;
      if (scl_i || tmo_hit) begin
        tmo_cnt_q <= scl_i ? 12'h0 : tmo_cnt_q;
      end else if (tick) begin
        tmo_cnt_q <= tmo_cnt_q + 12'h1;
      end
    end
  end

  // ----------------------------------------------------------------------------
  // Registers and interrupts
  // ----------------------------------------------------------------------------
  wire logic [1:0] irq_set = {tmo_evt_q, done_q};
  wire logic [1:0] irq_clr = wr_clr ? pwdata[1:0] : 2'h0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= CTRL_RESET;
      addr_q <= 8'h0;
      tx_q <= 8'h0;
      irq_en_q <= 2'h0;
      irq_raw_q <= 2'h0;
      tmo_q <= TIMEOUT_RESET;
      prdata_q <= 32'h0;
      irq_q <= 1'b0;
    end else begin
      if (wr_ctrl) ctrl_q <= pwdata[2:0];
      if (wr_addr) addr_q <= pwdata[7:0];
      if (wr_tx) tx_q <= pwdata[7:0];
      if (wr_en) irq_en_q <= pwdata[1:0];
      if (wr_tmo) tmo_q <= pwdata[7:0];
      irq_raw_q <= (irq_raw_q & ~irq_clr) | irq_set;
      irq_q <= |(((irq_raw_q & ~irq_clr) | irq_set) & irq_en_q &
                 {2{wr_ctrl ? pwdata[CTRL_IRQ_MASTER_EN_BIT]
                            : ctrl_q[CTRL_IRQ_MASTER_EN_BIT]}});
      if (psel && !penable && !pwrite) prdata_q <= mapped ? rd_mux : 32'h0;
    end
  end

  assign scl_o = 1'b0;
  assign sda_o = 1'b0;
  assign scl_oe = scl_drv_q;
  assign sda_oe = sda_drv_q;

endmodule : i2c_master

// file: logic/i2c_master_pkg.sv
// Package of register map, field layout and timing constants for the I2C master.
package i2c_master_pkg;

  // ----------------------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------------------
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_ADDR = 8'h04;
  localparam logic [7:0] OFF_TXDATA = 8'h08;
  localparam logic [7:0] OFF_RXDATA = 8'h0C;
  localparam logic [7:0] OFF_CMD = 8'h10;
  localparam logic [7:0] OFF_STATUS = 8'h14;
  localparam logic [7:0] OFF_IRQ_RAW = 8'h18;
  localparam logic [7:0] OFF_IRQ_EN = 8'h1C;
  localparam logic [7:0] OFF_IRQ_CLR = 8'h20;
  localparam logic [7:0] OFF_IRQ_MASKED = 8'h24;
  localparam logic [7:0] OFF_LINE = 8'h28;
  localparam logic [7:0] OFF_TIMEOUT = 8'h2C;

  // ----------------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------------
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CTRL_FAST_BIT = 1;
  localparam int CTRL_IRQ_MASTER_EN_BIT = 2;
  localparam int IRQ_DATA_BIT = 0;
  localparam int IRQ_TIMEOUT_BIT = 1;
  localparam int CMD_START_BIT = 0;
  localparam int CMD_STOP_BIT = 1;
  localparam int CMD_ACK_BIT = 2;

  // ----------------------------------------------------------------------------
  // Reset values and timing
  // ----------------------------------------------------------------------------
  localparam logic [2:0] CTRL_RESET = 3'h0;
  localparam logic [7:0] TIMEOUT_RESET = 8'h00;
  localparam int PCLK_HZ = 40000000;
  localparam int RATE_STD_BPS = 100000;
  localparam int RATE_FAST_BPS = 400000;
  // One quarter of an SCL period per tick.
  localparam int QTR_STD = PCLK_HZ / (4 * RATE_STD_BPS);
  localparam int QTR_FAST = PCLK_HZ / (4 * RATE_FAST_BPS);

  typedef enum logic [1:0] {
    ERR_NONE = 2'h0,
    ERR_ADDR_NACK = 2'h1,
    ERR_DATA_NACK = 2'h2,
    err_code_arbitration_lost = 2'h3
  } err_code_e;

  typedef struct packed {
    logic scl;
    logic sda;
  } line_s;

endpackage : i2c_master_pkg

// file: sim/i2c_master_properties.sv
// Port-level assertion checker for the I2C master.
`timescale 1ns/1ps
module i2c_master_properties
  import i2c_master_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic scl_i,
  input wire logic scl_o,
  input wire logic scl_oe,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe,
  input wire logic irq
);
  logic [2:0] ctrl_q;
  logic [1:0] ien_q;
  logic [1:0] line_q;
  logic [2:0] stab_q;
  wire wr_acc = psel && penable && pwrite;
  // Shadow copies of the control and enable registers, and a line stability count.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= 3'h0;
      ien_q <= 2'h0;
      line_q <= 2'h3;
      stab_q <= 3'h0;
    end else begin
      ctrl_q <= (wr_acc && paddr == OFF_CTRL) ? pwdata[2:0] : ctrl_q;
      ien_q <= (wr_acc && paddr == OFF_IRQ_EN) ? pwdata[1:0] : ien_q;
      line_q <= {sda_i, scl_i};
      stab_q <= (line_q != {sda_i, scl_i}) ? 3'h0 : (stab_q == 3'h7 ? 3'h7 : stab_q + 3'h1);
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_rd(logic [7:0] a);
    psel && penable && !pwrite && paddr == a;
  endsequence
  sequence s_wr(logic [7:0] a);
    psel && penable && pwrite && paddr == a;
  endsequence
  a_idle_when_off: assert property (!ctrl_q[0] && !scl_oe && !sda_oe |=> !scl_oe && !sda_oe)
    else $error("bus driven while disabled");
  a_start_when_on: assert property (s_wr(OFF_CMD) ##0 (ctrl_q[0] && pwdata[0]) |-> ##[1:1000] sda_oe)
    else $error("no start after command");
  a_clear_drops_irq: assert property (s_wr(OFF_IRQ_CLR) ##0 (pwdata[1:0] == 2'h3) |-> ##2 !irq)
    else $error("irq stays after clear");
  a_irq_needs_source: assert property (ien_q == 2'h0 && $past(ien_q) == 2'h0 |-> !irq)
    else $error("irq with no source enabled");
  a_irq_needs_master: assert property (!ctrl_q[2] && !$past(ctrl_q[2]) |-> !irq)
    else $error("irq with master enable off");
  a_masked_in_en: assert property (s_rd(OFF_IRQ_MASKED) |-> (prdata[1:0] & ~ien_q) == 2'h0)
    else $error("masked status shows disabled source");
  a_line_readout: assert property (s_rd(OFF_LINE) ##0 (stab_q == 3'h7) |-> prdata[1:0] == line_q)
    else $error("line readout wrong");
  a_open_drain: assert property (scl_o == 1'b0 && sda_o == 1'b0)
    else $error("pin driven high");
endmodule : i2c_master_properties

bind i2c_master i2c_master_properties u_props (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .scl_i(scl_i), .scl_o(scl_o), .scl_oe(scl_oe),
  .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe), .irq(irq));

// file: sim/i2c_target_model.sv
// Behavioural bus target: acks its own address, records bytes and the clock period.
`timescale 1ns/1ps
module i2c_target_model #(
  parameter logic [6:0] ADDR = 7'h2A
) (
  input wire logic pclk,
  input wire logic scl,
  input wire logic sda,
  input wire logic nack_data,
  output logic sda_oe,
  output logic [7:0] got_addr,
  output logic [7:0] got_data,
  output int scl_per
);
  logic scl_q = 1'b1;
  logic sda_q = 1'b1;
  logic hit = 1'b0;
  logic [7:0] sh = 8'h00;
  int bits = 0;
  int idx = 0;
  int cnt = 0;
  int last = 0;
  initial begin
    sda_oe = 1'b0;
    got_addr = 8'h00;
    got_data = 8'h00;
    scl_per = 0;
  end
  // The acknowledge is driven from the falling clock after the eighth bit.
  always @(posedge pclk) begin
    cnt <= cnt + 1;
    scl_q <= scl;
    sda_q <= sda;
    if (scl && scl_q && sda_q && !sda) begin
      bits <= 0;
      idx <= 0;
    end else if (scl && !scl_q) begin
      sh <= {sh[6:0], sda};
      bits <= bits + 1;
      last <= cnt;
      scl_per <= (bits > 0 && bits < 8) ? cnt - last : scl_per;
    end else if (!scl && scl_q && bits == 8) begin
      got_addr <= (idx == 0) ? sh : got_addr;
      got_data <= (idx == 0) ? got_data : sh;
      hit <= (idx == 0) ? (sh[7:1] == ADDR) : hit;
      sda_oe <= (idx == 0) ? (sh[7:1] == ADDR) : (hit && !nack_data);
    end else if (!scl && scl_q) begin
      sda_oe <= 1'b0;
      bits <= (bits == 9) ? 0 : bits;
      idx <= (bits == 9) ? idx + 1 : idx;
    end
  end
endmodule : i2c_target_model

// file: sim/i2c_master_bench.sv
// Self-checking bench for the I2C master: registers, transfers and interrupts.
`timescale 1ns/1ps
module i2c_master_bench;
  import i2c_master_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic hold_low = 1'b0;
  logic hold_scl = 1'b0;
  logic nack = 1'b0;
  logic [31:0] prdata;
  logic pready, pslverr, scl_o, scl_oe, sda_o, sda_oe, irq, t_oe;
  logic [7:0] got_addr, got_data;
  int scl_per;
  int num_errors = 0;
  int num_checks = 0;
  logic [31:0] exp_q[$];
  logic [31:0] msk_q[$];
  wire scl_i = !(scl_oe || hold_scl);
  wire sda_i = !(sda_oe || t_oe || hold_low);
  always #12.5 pclk = !pclk;
  i2c_master dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .scl_i(scl_i), .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda_i),
    .sda_o(sda_o), .sda_oe(sda_oe), .irq(irq));
  i2c_target_model #(.ADDR(7'h2A)) peer (.pclk(pclk), .scl(scl_i), .sda(sda_i),
    .nack_data(nack), .sda_oe(t_oe), .got_addr(got_addr), .got_data(got_data),
    .scl_per(scl_per));
  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, e, g);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    apb(1'b1, a, d, q);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m,
                    output logic [31:0] q);
    exp_q.push_back(e);
    msk_q.push_back(m);
    apb(1'b0, a, 32'h0, q);
  endtask : rd
  task automatic wrap_up();
    if (num_errors == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : wrap_up
  // Read results are compared against the oldest noted expectation.
  always @(posedge pclk) begin : watch
    logic [31:0] e;
    logic [31:0] m;
    if (psel && penable && !pwrite && pready === 1'b1 && exp_q.size() > 0) begin
      e = exp_q.pop_front();
      m = msk_q.pop_front();
      if (m != 32'h0) chk($sformatf("read %h", paddr), e & m, prdata & m);
    end
  end
  initial begin
    repeat (80000) @(posedge pclk);
    num_errors++;
    wrap_up();
  end
  initial begin
    logic [31:0] q;
    logic [7:0] tx, ad;
    logic [1:0] ien, err;
    logic fast, men;
    void'($urandom(32'hFF28));
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rd(OFF_CTRL, 32'h0, 32'hFFFFFFFF, q);
    rd(8'h30, 32'h0, 32'hFFFFFFFF, q);
    hold_low <= 1'b1;
    repeat (10) @(posedge pclk);
    rd(OFF_LINE, 32'h1, 32'h3, q);
    hold_low <= 1'b0;
    wr(OFF_CMD, 32'h3);
    repeat (20) @(posedge pclk);
    rd(OFF_STATUS, 32'h0, 32'h1, q);
    for (int i = 0; i < 3; i++) begin
      fast = (i != 0);
      men = (i != 2);
      ien = (i == 0) ? 2'h1 : (i == 1) ? 2'h2 : 2'h3;
      err = (i == 0) ? ERR_NONE : (i == 1) ? ERR_DATA_NACK : ERR_ADDR_NACK;
      ad = (i == 2) ? {7'h15, 1'b1} : {7'h2A, 1'b0};
      tx = 8'($urandom);
      nack <= (i == 1);
      wr(OFF_CTRL, {29'h0, men, fast, 1'b1});
      wr(OFF_IRQ_EN, {30'h0, ien});
      wr(OFF_ADDR, {24'h0, ad});
      wr(OFF_TXDATA, {24'h0, tx});
      wr(OFF_CMD, 32'h3);
      q = 32'h1;
      for (int k = 0; k < 5000 && q[0] !== 1'b0; k++) rd(OFF_STATUS, 32'h0, 32'h0, q);
      rd(OFF_STATUS, {29'h0, err, 1'b0}, 32'h7, q);
      chk("address byte", {24'h0, ad}, {24'h0, got_addr});
      if (i < 2) chk("data byte", {24'h0, tx}, {24'h0, got_data});
      chk("scl period", 32'(4 * (fast ? QTR_FAST : QTR_STD)), 32'(scl_per));
      rd(OFF_IRQ_RAW, 32'h1, 32'h3, q);
      chk("irq level", {31'h0, men & ien[0]}, {31'h0, irq});
      rd(OFF_IRQ_MASKED, {30'h0, ien & {1'b0, men}}, 32'h3, q);
      wr(OFF_IRQ_CLR, 32'h2);
      rd(OFF_IRQ_RAW, 32'h1, 32'h3, q);
      wr(OFF_IRQ_CLR, 32'h3);
      rd(OFF_IRQ_RAW, 32'h0, 32'h3, q);
      chk("irq cleared", 32'h0, {31'h0, irq});
    end
    wr(OFF_TIMEOUT, 32'h1);
    wr(OFF_IRQ_EN, 32'h2);
    wr(OFF_CTRL, 32'h7);
    hold_scl <= 1'b1;
    repeat (200) @(posedge pclk);
    rd(OFF_IRQ_RAW, 32'h0, 32'h3, q);
    repeat (400) @(posedge pclk);
    rd(OFF_IRQ_RAW, 32'h2, 32'h3, q);
    chk("timeout irq", 32'h1, {31'h0, irq});
    wr(OFF_IRQ_CLR, 32'h2);
    rd(OFF_IRQ_RAW, 32'h0, 32'h3, q);
    chk("irq after clear", 32'h0, {31'h0, irq});
    hold_scl <= 1'b0;
    wrap_up();
  end
endmodule : i2c_master_bench
